// ---- hdl/asf_fifo_map.vh ----
// Purpose: Constants for the audio sample FIFO controller.
// Assumes: Included by hdl/asf_fifo_ctrl.v only.
// Notes: Each FIFO owns a quarter of its shared memory.
`ifndef ASF_FIFO_MAP_VH
`define ASF_FIFO_MAP_VH
`define ASF_NUM_FIFOS     8
`define ASF_FIFOS_PER_MEM 4
`define ASF_ID_W          3
`define ASF_DATA_W        48
`define ASF_MEM_DEPTH     1024
`define ASF_MEM_AW        10
`define ASF_SLOT_AW       8
`define ASF_BLK_W         8
`define ASF_BLK_RST       8'h00
`define ASF_PTR_RST       8'h00
`endif

// ---- hdl/asf_fifo_ctrl.v ----
// Purpose: Audio sample FIFO controller with per-FIFO block counters and events.
// Assumes: The audio sample mover presents one sample request at a time.
// Notes: One shared port serves both memories; a request to fifo_memory_a and
//   fifo_memory_b are never taken in the same cycle.
// Summary of operation
// - Eight FIFOs exist, four in fifo_memory_a and four in fifo_memory_b.
// - Once configured, transfers run with no further software action.
// - Each FIFO has a block counter that advances once per sample moved.
// - On block completion the FIFO's interrupt pulses, its counter updates and pointers advance.
// - The FIFO interrupts go out as sources for the DSP interrupt controller.
`timescale 1ns/10ps
`default_nettype none
`include "asf_fifo_map.vh"

// Block counter and pointer pair of one FIFO; one copy per FIFO.
module asf_fifo_slot #(
  parameter BLK_W = `ASF_BLK_W,
  parameter PTR_W = `ASF_SLOT_AW
) (
  // Clock and reset.
  input  wire             sys_clk,
  input  wire             rst_n,
  // Access taken for this FIFO.
  input  wire             hit,
  input  wire             is_write,
  input  wire [BLK_W-1:0] blk_len,
  // State seen by the shared datapath.
  output wire [PTR_W-1:0] rd_ptr,
  output wire [PTR_W-1:0] wr_ptr,
  output wire [BLK_W-1:0] cnt_next,
  output wire             blk_done
);

  reg  [BLK_W-1:0] blk_cnt_reg;
  reg  [BLK_W-1:0] blk_cnt_next;
  reg  [PTR_W-1:0] rd_ptr_reg;
  reg  [PTR_W-1:0] rd_ptr_next;
  reg  [PTR_W-1:0] wr_ptr_reg;
  reg  [PTR_W-1:0] wr_ptr_next;

  assign rd_ptr   = rd_ptr_reg;
  assign wr_ptr   = wr_ptr_reg;
  assign cnt_next = blk_cnt_reg + {{(BLK_W-1){1'h0}}, 1'h1};
  // A zero block length is treated as one, so a FIFO cannot go silent.
  assign blk_done = (cnt_next >= blk_len);

  always @* begin
    blk_cnt_next = blk_cnt_reg;
    rd_ptr_next  = rd_ptr_reg;
    wr_ptr_next  = wr_ptr_reg;
    if (hit) begin
      // Pointers move on every sample, so they also step past a finished block.
      if (is_write)
        wr_ptr_next = wr_ptr_reg + {{(PTR_W-1){1'h0}}, 1'h1};
      else
        rd_ptr_next = rd_ptr_reg + {{(PTR_W-1){1'h0}}, 1'h1};
      if (blk_done)
        blk_cnt_next = `ASF_BLK_RST;
      else
        blk_cnt_next = cnt_next;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      blk_cnt_reg <= `ASF_BLK_RST;
      rd_ptr_reg  <= `ASF_PTR_RST;
      wr_ptr_reg  <= `ASF_PTR_RST;
    end else begin
      blk_cnt_reg <= blk_cnt_next;
      rd_ptr_reg  <= rd_ptr_next;
      wr_ptr_reg  <= wr_ptr_next;
    end
  end

endmodule // asf_fifo_slot

// Two-entry buffer with valid and ready on both sides.
module asf_rd_buf #(
  parameter DATA_W = `ASF_DATA_W
) (
  // Clock and reset.
  input  wire              sys_clk,
  input  wire              rst_n,
  // Write side.
  input  wire              in_valid,
  output wire              in_ready,
  input  wire [DATA_W-1:0] in_data,
  // Read side.
  output wire              out_valid,
  input  wire              out_ready,
  output wire [DATA_W-1:0] out_data
);

  reg  [DATA_W-1:0] slot_data_reg [0:1];
  reg               wp_reg;
  reg               rp_reg;
  reg  [1:0]        cnt_reg;
  reg  [1:0]        cnt_next;
  wire              push;
  wire              pop;

  // Two entries let a full-rate stream pass; a one-cycle reader stall drops in_ready for the next cycle.
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = slot_data_reg[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    cnt_next = cnt_reg;
    if (push & ~pop)
      cnt_next = cnt_reg + 2'h1;
    else if (pop & ~push)
      cnt_next = cnt_reg - 2'h1;
  end

  always @(posedge sys_clk) begin
    if (push)
      slot_data_reg[wp_reg] <= in_data;
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wp_reg  <= 1'h0;
      rp_reg  <= 1'h0;
      cnt_reg <= 2'h0;
    end else begin
      if (push)
        wp_reg <= ~wp_reg;
      if (pop)
        rp_reg <= ~rp_reg;
      cnt_reg <= cnt_next;
    end
  end

endmodule // asf_rd_buf

module asf_fifo_ctrl (
  // Clock and reset.
  input  wire                            sys_clk,
  input  wire                            rst_n,
  // Configuration.
  input  wire [`ASF_NUM_FIFOS-1:0]       cfg_enable,
  input  wire [`ASF_NUM_FIFOS*`ASF_BLK_W-1:0] cfg_block_len,
  // Sample request from the audio sample mover.
  input  wire                            req_valid,
  output wire                            req_ready,
  input  wire                            req_write,
  input  wire [`ASF_ID_W-1:0]            req_fifo,
  input  wire [`ASF_DATA_W-1:0]          req_wdata,
  // Read data towards the audio sample mover.
  output wire                            rd_valid,
  input  wire                            rd_ready,
  output wire [`ASF_DATA_W-1:0]          rd_data,
  // Events.
  output reg  [`ASF_NUM_FIFOS-1:0]       fifo_irq,
  output reg  [`ASF_NUM_FIFOS-1:0]       chain_event,
  // Block progress of the selected FIFO.
  output reg  [`ASF_BLK_W-1:0]           blk_count_out
);

  // Both shared memories, modelled as two arrays.
  reg [`ASF_DATA_W-1:0] mem_a [0:`ASF_MEM_DEPTH-1];
  reg [`ASF_DATA_W-1:0] mem_b [0:`ASF_MEM_DEPTH-1];

  wire [`ASF_NUM_FIFOS*`ASF_SLOT_AW-1:0] rd_ptr_all;
  wire [`ASF_NUM_FIFOS*`ASF_SLOT_AW-1:0] wr_ptr_all;
  wire [`ASF_NUM_FIFOS*`ASF_BLK_W-1:0]   cnt_next_all;
  wire [`ASF_NUM_FIFOS-1:0]              done_all;
  wire [`ASF_NUM_FIFOS-1:0]              hit_all;

  wire                    buf_in_ready;
  wire                    take;
  wire                    rd_take;
  wire                    mem_sel;
  wire [`ASF_SLOT_AW-1:0] slot_ptr;
  wire [`ASF_MEM_AW-1:0]  mem_addr;
  wire [`ASF_DATA_W-1:0]  mem_rdata;
  wire [`ASF_BLK_W-1:0]   cnt_sel;
  wire                    blk_done;

  reg  [`ASF_NUM_FIFOS-1:0] fifo_irq_next;
  reg  [`ASF_NUM_FIFOS-1:0] chain_event_next;
  reg  [`ASF_BLK_W-1:0]     blk_count_next;

  genvar                  g;

  // Reads stall while the buffer is full, so back-pressure reaches the mover.
  assign req_ready = cfg_enable[req_fifo] & (req_write | buf_in_ready);
  assign take      = req_valid & req_ready;
  assign rd_take   = take & ~req_write;

  // Upper id bit picks the memory, low two bits the quarter within it.
  assign mem_sel   = req_fifo[`ASF_ID_W-1];
  assign slot_ptr  = req_write ? wr_ptr_all[req_fifo*`ASF_SLOT_AW +: `ASF_SLOT_AW] :
                                 rd_ptr_all[req_fifo*`ASF_SLOT_AW +: `ASF_SLOT_AW];
  assign mem_addr  = {req_fifo[1:0], slot_ptr};
  assign mem_rdata = mem_sel ? mem_b[mem_addr] : mem_a[mem_addr];
  assign cnt_sel   = cnt_next_all[req_fifo*`ASF_BLK_W +: `ASF_BLK_W];
  assign blk_done  = done_all[req_fifo];

  generate
    for (g = 0; g < `ASF_NUM_FIFOS; g = g + 1) begin : g_slot
      localparam [`ASF_ID_W-1:0] SLOT_ID = g;
      assign hit_all[g] = take & (req_fifo == SLOT_ID);
      asf_fifo_slot #(
        .BLK_W (`ASF_BLK_W),
        .PTR_W (`ASF_SLOT_AW)
      ) u_slot (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .hit      (hit_all[g]),
        .is_write (req_write),
        .blk_len  (cfg_block_len[g*`ASF_BLK_W +: `ASF_BLK_W]),
        .rd_ptr   (rd_ptr_all[g*`ASF_SLOT_AW +: `ASF_SLOT_AW]),
        .wr_ptr   (wr_ptr_all[g*`ASF_SLOT_AW +: `ASF_SLOT_AW]),
        .cnt_next (cnt_next_all[g*`ASF_BLK_W +: `ASF_BLK_W]),
        .blk_done (done_all[g])
      );
    end
  endgenerate

  // The read sample is parked so a stalled reader drops none.
  asf_rd_buf #(
    .DATA_W (`ASF_DATA_W)
  ) u_rd_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (rd_take),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rdata),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  always @* begin
    fifo_irq_next    = {`ASF_NUM_FIFOS{1'h0}};
    chain_event_next = {`ASF_NUM_FIFOS{1'h0}};
    blk_count_next   = blk_count_out;
    if (take) begin
      if (blk_done) begin
        fifo_irq_next[req_fifo]    = 1'h1;
        chain_event_next[req_fifo] = 1'h1;
        blk_count_next             = `ASF_BLK_RST;
      end else begin
        blk_count_next             = cnt_sel;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (take & req_write) begin
      if (mem_sel)
        mem_b[mem_addr] <= req_wdata;
      else
        mem_a[mem_addr] <= req_wdata;
    end
  end

  // Events are registered so they reach both consumers as clean pulses.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      fifo_irq      <= {`ASF_NUM_FIFOS{1'h0}};
      chain_event   <= {`ASF_NUM_FIFOS{1'h0}};
      blk_count_out <= `ASF_BLK_RST;
    end else begin
      fifo_irq      <= fifo_irq_next;
      chain_event   <= chain_event_next;
      blk_count_out <= blk_count_next;
    end
  end

endmodule // asf_fifo_ctrl
`default_nettype wire

// ---- sim/asf_chk_sva.sv ----
// Purpose: Port checks. Assumes: bound. Notes: Config steady.
`timescale 1ns/10ps
`default_nettype none
module asf_chk (
  input wire       sys_clk, rst_n, req_valid, req_ready, req_write, rd_valid, rd_ready,
  input wire [7:0] cfg_enable, fifo_irq, chain_event, blk_count_out,
  input wire [2:0] req_fifo,
  input wire [47:0] rd_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire tk = req_valid && req_ready;
  property p_ev; fifo_irq == chain_event; endproperty
  a_ev: assert property (p_ev) else $error("ev");
  property p_irq; |fifo_irq |-> $past(tk) && fifo_irq == 8'h01 << $past(req_fifo); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_off; !cfg_enable[req_fifo] |-> !req_ready; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_zero; |fifo_irq |-> blk_count_out == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_cnt; tk |=> |fifo_irq || blk_count_out != 8'h00; endproperty
  a_cnt: assert property (p_cnt) else $error("cnt");
  property p_rd; tk && !req_write |=> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_hold; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_idle; !rd_valid && !(tk && !req_write) |=> !rd_valid; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  c_irq: cover property (|fifo_irq);
  c_full: cover property (req_valid && !req_write && cfg_enable[req_fifo] && !req_ready);
  c_wr: cover property (tk && req_write);
endmodule // asf_chk
bind asf_fifo_ctrl asf_chk u_chk (.*);
`default_nettype wire

// ---- sim/asf_sink_model.sv ----
// Purpose: Reader model. Assumes: one clock. Notes: Stalls in bursts to fill the buffer.
`timescale 1ns/10ps
`default_nettype none
module asf_sink_model (
  input  wire  sys_clk,
  output logic rd_ready
);
  logic [3:0] cnt_reg = 4'h0;
  initial rd_ready = 1'h0;
  always @(posedge sys_clk) begin
    cnt_reg <= cnt_reg + 4'h1;
    rd_ready <= #2 cnt_reg[3];
  end
endmodule // asf_sink_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Bench. Assumes: mover trusted. Notes: FIFO n has block length n.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module tb_top;
  logic        sys_clk = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0, tk = 1'h0;
  logic [2:0]  req_fifo = 3'h0, f;
  logic [47:0] req_wdata = 48'h0, m [8][256], qd [$];
  logic [7:0]  wp [8], rp [8], cnt [8], c;
  logic [15:0] lfsr = 16'h0010;
  logic [23:0] qi [$];
  wire         req_ready, rd_valid, rd_ready;
  wire [47:0]  rd_data;
  wire [7:0]   fifo_irq, chain_event, blk_count_out;
  int          num_errors = 0, total_checks = 0, n, i;
  always #5 sys_clk = ~sys_clk;
  asf_fifo_ctrl uut (.*, .cfg_enable(8'hEF), .cfg_block_len(64'h0706050403020100));
  asf_sink_model snk (.*);
  function automatic logic [15:0] lf();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(negedge sys_clk) begin
    if (tk) begin
      `CHK({fifo_irq, chain_event, blk_count_out}, qi.pop_front())
      tk = 1'h0;
    end
    if (rd_valid && rd_ready) `CHK(rd_data, qd.pop_front())
  end
  initial begin
    for (n = 0; n < 8; n++) begin
      wp[n] = 8'h00;
      rp[n] = 8'h00;
      cnt[n] = 8'h00;
    end
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'h1;
    req_fifo = 3'h4;
    req_valid = 1'h1;
    #1 `CHK(req_ready, 1'h0)
    @(posedge sys_clk) #1;
    for (i = 0; i < 300; i++) begin
      c = lf();
      f = c[2:0] == 3'h4 ? 3'h5 : c[2:0];
      req_write = c[3] | rp[f] == wp[f];
      req_fifo = f;
      req_wdata = {lf(), lf(), lf()};
      #1;
      for (n = 0; n < 50 && req_ready !== 1'h1; n++) @(posedge sys_clk) #1;
      if (req_ready !== 1'h1) begin
        num_errors++;
        results();
      end
      if (req_write) m[f][wp[f]++] = req_wdata; else qd.push_back(m[f][rp[f]++]);
      c = cnt[f] + 8'h1;
      cnt[f] = c >= f ? 8'h00 : c;
      qi.push_back({{2{cnt[f] == 8'h00 ? 8'h01 << f : 8'h00}}, cnt[f]});
      @(posedge sys_clk) tk = 1'h1;
      #1;
    end
    req_valid = 1'h0;
    for (n = 0; n < 99 && qd.size() > 0; n++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    `CHK(qd.size(), 0)
    `CHK(qi.size(), 0)
    $display("test traffic done");
    results();
  end
endmodule // tb_top
`default_nettype wire
